//--- pkg/pgp_pkg.sv
// constants and carrier types for the port 0 / port 1 parallel i/o block
// Summary of operation
// R1 - all block registers decode only inside special-function window 0000H to 003FH
// R2 - software never touches reserved or direction-inaccessible locations
// R3 - software never uses read-modify-write on write-only or interrupt-latch registers
// R4 - output bits live in latches; inputs are live pin levels, unlatched; code reads pins through the two-flop pgp_sync, two clocks late
// R5 - pin levels for a read are sampled at the read-cycle S1 strobe
// R6 - output latch and driven pin change at the write-cycle S2 strobe
// R7 - software filters chatter itself by reading repeatedly
// R8 - reset sets all port 0 latch bits to one
// R9 - software writes one to port 0 bits used as input or secondary function
// R10 - port 0 latch address reads latch; pin-state address reads pin levels
// R11 - control bit 6 picks port 0 bit 0 as i/o or interrupt; reset is i/o
// R12 - select zero routes bit 0 as i/o, one as interrupt input
// R13 - port 1 direction bit zero means input, one means output, per bit
// R14 - reset clears port 1 direction and latch, all pins inputs
// R15 - software clears direction bit for inputs, interrupt or counter inputs
// R16 - for counter or divider outputs software sets latch then direction
// R17 - port 1 latch writes are accepted whatever the direction bit
// R18 - software loads the latch before switching a pin to output
// R19 - port 1 read gives pin for input bits, latch for output bits
// R20 - write after mixed read overwrites input-bit latches with read pin levels
// R21 - port 0 pin driven low for latch zero, released for latch one
package pgp_pkg;
    localparam int         PGP_AW           = 16;
    localparam int         PGP_DW           = 8;
    localparam logic [15:0] PGP_SFR_LO      = 16'h0000;
    localparam logic [15:0] PGP_SFR_HI      = 16'h003F;
    localparam logic [15:0] PGP_P0_LATCH    = 16'h0000;
    localparam logic [15:0] PGP_P1_LATCH    = 16'h0001;
    localparam logic [15:0] PGP_P0_PINS     = 16'h0008;
    localparam logic [15:0] PGP_P1_DIR      = 16'h000D;
    localparam logic [15:0] PGP_EIRQ_CTRL   = 16'h0037;
    localparam int          PGP_EIRQ_SEL_BIT = 6;
    localparam logic [7:0]  PGP_P0_RESET    = 8'hFF;
    localparam logic [7:0]  PGP_P1_RESET    = 8'h00;
    localparam logic [7:0]  PGP_DIR_RESET   = 8'h00;
    localparam logic        PGP_SEL_RESET   = 1'h0;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd_s1;
        logic        wr_s2;
    } pgp_sfr_req_s;
endpackage

//--- hdl/pgp_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pgp_sync
    import pgp_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

//--- hdl/pgp_ports.sv
// port 0 and port 1 parallel i/o with their special-function registers
`timescale 1ns/1ps
module pgp_ports
    import pgp_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_srst,
    input  wire pgp_sfr_req_s i_sfr,
    output logic              o_sfr_hit,
    output logic [7:0]        o_rdata,
    input  wire logic [7:0]   i_p0_pin,
    output logic [7:0]        o_p0_out,
    output logic [7:0]        o_p0_oe,
    input  wire logic [7:0]   i_p1_pin,
    output logic [7:0]        o_p1_out,
    output logic [7:0]        o_p1_oe,
    output logic              o_ext_irq0_input
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [7:0] p0_pin_s;
    logic [7:0] p1_pin_s;

    pgp_sync #(.W(8)) u_sync_p0 (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (i_p0_pin),
        .o_sync  (p0_pin_s)
    );

    pgp_sync #(.W(8)) u_sync_p1 (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_async (i_p1_pin),
        .o_sync  (p1_pin_s)
    );

    // ****************************************
    // address decode
    // ****************************************
    logic in_window;
    logic wr_p0;
    logic wr_p1;
    logic wr_dir;
    logic wr_eirq;

    assign in_window = (i_sfr.addr >= PGP_SFR_LO) && (i_sfr.addr <= PGP_SFR_HI); // [R1]
    assign o_sfr_hit = in_window && ((i_sfr.addr == PGP_P0_LATCH) || (i_sfr.addr == PGP_P1_LATCH)
                       || (i_sfr.addr == PGP_P0_PINS) || (i_sfr.addr == PGP_P1_DIR)
                       || (i_sfr.addr == PGP_EIRQ_CTRL));
    assign wr_p0   = i_sfr.wr_s2 && in_window && (i_sfr.addr == PGP_P0_LATCH);
    assign wr_p1   = i_sfr.wr_s2 && in_window && (i_sfr.addr == PGP_P1_LATCH);
    assign wr_dir  = i_sfr.wr_s2 && in_window && (i_sfr.addr == PGP_P1_DIR);
    assign wr_eirq = i_sfr.wr_s2 && in_window && (i_sfr.addr == PGP_EIRQ_CTRL);

    // ****************************************
    // port 0 latch
    // ****************************************
    logic [7:0] p0_latch_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            p0_latch_reg <= PGP_P0_RESET; // [R8]
        end else if (wr_p0) begin
            p0_latch_reg <= i_sfr.wdata; // [R4] [R6]
        end
    end

    // ****************************************
    // port 1 latch and direction
    // ****************************************
    logic [7:0] p1_latch_reg;
    logic [7:0] p1_dir_reg;

    // every bit stored regardless of direction; a read-back write refreshes input bits
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            p1_latch_reg <= PGP_P1_RESET; // [R14]
        end else if (wr_p1) begin
            p1_latch_reg <= i_sfr.wdata; // [R6] [R17] [R20]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            p1_dir_reg <= PGP_DIR_RESET; // [R14]
        end else if (wr_dir) begin
            p1_dir_reg <= i_sfr.wdata; // [R13]
        end
    end

    // ****************************************
    // interrupt pin select
    // ****************************************
    logic eirq_sel_reg;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            eirq_sel_reg <= PGP_SEL_RESET; // [R11]
        end else if (wr_eirq) begin
            eirq_sel_reg <= i_sfr.wdata[PGP_EIRQ_SEL_BIT]; // [R11]
        end
    end

    // idle high when not routed, since the interrupt fires on a falling edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_ext_irq0_input <= 1'h1;
        end else begin
            o_ext_irq0_input <= eirq_sel_reg ? p0_pin_s[0] : 1'h1; // [R12]
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    assign o_p0_out = 8'h00;
    assign o_p0_oe  = ~p0_latch_reg; // [R21]
    assign o_p1_out = p1_latch_reg;
    assign o_p1_oe  = p1_dir_reg; // [R13]

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (in_window) begin // [R1]
            unique case (i_sfr.addr)
                PGP_P0_LATCH:  rd_mux = p0_latch_reg; // [R10]
                PGP_P0_PINS:   rd_mux = p0_pin_s; // [R4] [R10]
                PGP_P1_LATCH:  rd_mux = (p1_dir_reg & p1_latch_reg) | (~p1_dir_reg & p1_pin_s); // [R19]
                PGP_P1_DIR:    rd_mux = p1_dir_reg;
                PGP_EIRQ_CTRL: rd_mux = {1'h0, eirq_sel_reg, 6'h00};
                default:       rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else if (i_sfr.rd_s1) begin
            o_rdata <= rd_mux; // [R5]
        end
    end

    // ****************************************
    // checks
    // ****************************************
    p0_reset_ones_a: assert property (@(posedge i_clk) i_srst |=> p0_latch_reg == PGP_P0_RESET) // [R8]
        else $error("port 0 latch not all ones after reset");

    p1_reset_clear_a: assert property (@(posedge i_clk) // [R14]
        i_srst |=> (p1_dir_reg == PGP_DIR_RESET) && (p1_latch_reg == PGP_P1_RESET))
        else $error("port 1 not cleared by reset");

    p0_write_update_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R6]
        wr_p0 |=> o_p0_oe == ~$past(i_sfr.wdata))
        else $error("port 0 pins not updated by write");

    p1_write_any_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R17]
        wr_p1 |=> o_p1_out == $past(i_sfr.wdata))
        else $error("port 1 latch write lost");

    p0_latch_hold_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R4]
        !wr_p0 |=> $stable(p0_latch_reg))
        else $error("port 0 latch changed without write");

    p1_read_mix_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R19]
        i_sfr.rd_s1 && in_window && i_sfr.addr == PGP_P1_LATCH |=>
        o_rdata == (($past(p1_dir_reg) & $past(p1_latch_reg)) | (~$past(p1_dir_reg) & $past(p1_pin_s))))
        else $error("port 1 read mixes pins and latch wrongly");

    p0_pin_read_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R5] [R10]
        i_sfr.rd_s1 && i_sfr.addr == PGP_P0_PINS |=> o_rdata == $past(p0_pin_s))
        else $error("port 0 pin-state read wrong");

    outside_window_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R1]
        i_sfr.addr > PGP_SFR_HI |-> !o_sfr_hit)
        else $error("decode outside special-function window");

    irq_route_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R12]
        !eirq_sel_reg |=> o_ext_irq0_input)
        else $error("interrupt input active while routed as i/o");

    p0_drive_low_a: assert property (@(posedge i_clk) disable iff (i_srst) // [R21]
        o_p0_out == 8'h00 && o_p0_oe == ~p0_latch_reg)
        else $error("port 0 open-drain drive wrong");
endmodule

//--- bench/pgp_pins_model.sv
// pin-side circuitry model for port 0 and port 1
`timescale 1ns/1ps
module pgp_pins_model
    import pgp_pkg::*;
(
    input  wire logic [7:0] i_p0_oe,
    input  wire logic [7:0] i_p0_ext,
    input  wire logic [7:0] i_p1_oe,
    input  wire logic [7:0] i_p1_out,
    input  wire logic [7:0] i_p1_ext,
    output logic      [7:0] o_p0_pin,
    output logic      [7:0] o_p1_pin
);
    // open drain with pull-up: low where driven, else external level
    assign o_p0_pin = ~i_p0_oe & i_p0_ext;
    // output bits show the latch, input bits the external level
    assign o_p1_pin = (i_p1_oe & i_p1_out) | (~i_p1_oe & i_p1_ext);
endmodule

//--- bench/tb.sv
// self-checking testbench for the port 0 / port 1 block
`timescale 1ns/1ps
module tb
    import pgp_pkg::*;
;
    logic         i_clk  = 1'b0;
    logic         i_srst = 1'b1;
    pgp_sfr_req_s sfr    = '0;
    logic [7:0]   p0_ext = 8'hFF;
    logic [7:0]   p1_ext = 8'h3C;
    logic         hit;
    logic [7:0]   rdata, p0_pin, p0_out, p0_oe, p1_pin, p1_out, p1_oe;
    logic         irq;
    int           n_mismatch  = 0;
    int           checks_done = 0;

    always #2.5 i_clk = ~i_clk;

    pgp_ports DUT (.i_clk(i_clk), .i_srst(i_srst), .i_sfr(sfr), .o_sfr_hit(hit), .o_rdata(rdata),
        .i_p0_pin(p0_pin), .o_p0_out(p0_out), .o_p0_oe(p0_oe), .i_p1_pin(p1_pin), .o_p1_out(p1_out),
        .o_p1_oe(p1_oe), .o_ext_irq0_input(irq));
    pgp_pins_model pins (.i_p0_oe(p0_oe), .i_p0_ext(p0_ext), .i_p1_oe(p1_oe), .i_p1_out(p1_out),
        .i_p1_ext(p1_ext), .o_p0_pin(p0_pin), .o_p1_pin(p1_pin));

    // ****************************************
    // tasks
    // ****************************************
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        sfr.addr  = a;
        sfr.wdata = d;
        sfr.wr_s2 = 1'b1;
        @(negedge i_clk);
        sfr.wr_s2 = 1'b0;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e, input string n);
        @(negedge i_clk);
        sfr.addr  = a;
        sfr.rd_s1 = 1'b1;
        @(negedge i_clk);
        sfr.rd_s1 = 1'b0;
        chk(n, e, rdata);
    endtask

    task complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (5) @(negedge i_clk);
        i_srst = 1'b0;
        chk("p0_oe", 8'h00, p0_oe);
        chk("p0_out", 8'h00, p0_out);
        chk("p1_oe", 8'h00, p1_oe);
        chk("p1_out", 8'h00, p1_out);
        chk("irq", 8'h01, {7'h0, irq});
        rd(PGP_P0_LATCH, 8'hFF, "p0_latch");
        rd(PGP_P1_LATCH, 8'h3C, "p1_read");
        rd(PGP_EIRQ_CTRL, 8'h00, "eirq");
        wr(PGP_P0_LATCH, 8'h5A);
        chk("p0_oe", 8'hA5, p0_oe);
        rd(PGP_P0_LATCH, 8'h5A, "p0_latch");
        rd(PGP_P0_PINS, 8'h5A, "p0_pins");
        wr(16'h0040, 8'h00);
        rd(PGP_P0_LATCH, 8'h5A, "p0_latch");
        rd(16'h0040, 8'h00, "unmapped");
        chk("hit", 8'h00, {7'h0, hit});
        p0_ext = 8'hF0;
        repeat (3) @(negedge i_clk);
        rd(PGP_P0_PINS, 8'h50, "p0_pins");
        rd(PGP_P0_PINS, 8'h50, "p0_pins");
        wr(PGP_P1_LATCH, 8'hF5);
        chk("p1_out", 8'hF5, p1_out);
        chk("p1_oe", 8'h00, p1_oe);
        wr(PGP_P1_DIR, 8'hF0);
        chk("p1_oe", 8'hF0, p1_oe);
        rd(PGP_P1_DIR, 8'hF0, "p1_dir");
        repeat (3) @(negedge i_clk);
        rd(PGP_P1_LATCH, 8'hFC, "p1_read");
        wr(PGP_P1_LATCH, 8'hFC);
        chk("p1_out", 8'hFC, p1_out);
        wr(PGP_P0_LATCH, 8'hFF);
        p0_ext = 8'hFE;
        wr(PGP_EIRQ_CTRL, 8'hFF);
        rd(PGP_EIRQ_CTRL, 8'h40, "eirq");
        repeat (4) @(negedge i_clk);
        chk("irq", 8'h00, {7'h0, irq});
        wr(PGP_EIRQ_CTRL, 8'h00);
        repeat (4) @(negedge i_clk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(PGP_P0_LATCH, 8'h00);
        i_srst = 1'b1;
        @(negedge i_clk);
        i_srst = 1'b0;
        chk("p1_oe", 8'h00, p1_oe);
        chk("p0_oe", 8'h00, p0_oe);
        complete_run();
    end
endmodule
